// *** verilog/adcp_map.svh ***
// constants of the converter output port: latency, widths, mode codes
// assumes inclusion by bare name from both ends and the interface
`ifndef ADCP_MAP_SVH
`define ADCP_MAP_SVH
// ----------------------------------------------------------------
// pipeline and word layout
// ----------------------------------------------------------------
`define ADCP_LATENCY 7
`define ADCP_WIDTH 16
`define ADCP_MSB 15
// ----------------------------------------------------------------
// four-level format strap codes: 0 ground, 1 third, 2 two thirds, 3 supply
// ----------------------------------------------------------------
`define ADCP_FMT_GND 2'h0
`define ADCP_FMT_THIRD 2'h1
`define ADCP_FMT_TWO_THIRD 2'h2
`define ADCP_FMT_SUPPLY 2'h3
// ----------------------------------------------------------------
// capture side status bits and register offsets
// ----------------------------------------------------------------
`define ADCP_ST_WORD 0
`define ADCP_ST_RANGE 1
`define ADCP_ST_LOST 2
`define ADCP_REG_DATA 4'h0
`define ADCP_REG_STATUS 4'h1
`define ADCP_REG_CLEAR 4'h2
`define ADCP_REG_ENABLE 4'h3
`define ADCP_REG_CTRL 4'h4
`endif

// *** verilog/adcp_pkg.sv ***
// types shared by both ends of the converter output port
// assumes adcp_map.svh is on the include path
`default_nettype none
`include "adcp_map.svh"
package adcp_pkg;
   // ----------------------------------------------------------------
   // output coding
   // ----------------------------------------------------------------
   typedef enum logic {ADCP_OFFSET_BIN, ADCP_TWOS_COMP} adcp_format_t;
   typedef logic [`ADCP_MSB:0] adcp_word_t;
endpackage
`default_nettype wire

// *** verilog/adcp_if.sv ***
// interface joining the converter output pins to the capture logic
// assumes the bench resolves the pins from the enables (low = driving)
`timescale 1ns/100ps
`default_nettype none
`include "adcp_map.svh"
interface adcp_if;
   logic sample_clock_p; // sample clock, true side
   logic sample_clock_n; // sample clock, complement
   adcp_pkg::adcp_word_t result_bus; // parallel result
   logic result_bus_oe_n; // low while result driven
   logic data_valid_n; // data valid, falls at capture
   logic data_valid_p; // inverse data valid
   logic range_flag; // over or underflow
   logic flag_oe_n; // low while valid/flag driven
   modport conv (input sample_clock_p, input sample_clock_n, output result_bus, output result_bus_oe_n,
      output data_valid_n, output data_valid_p, output range_flag, output flag_oe_n);
   modport capt (output sample_clock_p, output sample_clock_n, input result_bus, input result_bus_oe_n,
      input data_valid_n, input data_valid_p, input range_flag, input flag_oe_n);
endinterface
`default_nettype wire

// *** verilog/adcp_conv.sv ***
// converter end: sample pipeline, coding, scrambling and output drivers
// assumes a sample clock pair from the capture end far slower than CLK
`timescale 1ns/100ps
`default_nettype none
`include "adcp_map.svh"
module adcp_conv #(
   parameter int LATENCY = `ADCP_LATENCY
) (
   input wire logic CLK,
   input wire logic RST_N,
   adcp_if.conv LINK,
   input wire logic [15:0] SAMPLE_IN,
   input wire logic SAMPLE_OVER,
   input wire logic POWER_DOWN,
   input wire logic NOISE_INJECTION_EN,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic [1:0] FORMAT_LEVEL,
   input wire logic OUTPUT_SCRAMBLE_SEL,
   input wire logic GAIN_SELECT,
   output logic STABILIZER_ON,
   output logic DITHER_ON,
   output logic HIGH_GAIN
);
   // ----------------------------------------------------------------
   // synchronisers for pins
   // ----------------------------------------------------------------
   logic [7:0] s1_reg; // first stage, read only by second
   logic [7:0] s2_reg; // second stage
   logic clk_prev_reg; // previous synced sample clock
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
         clk_prev_reg <= 1'b0;
      end else begin
         // both clock pins synced apart, compared only after the second stage
         s1_reg <= {LINK.sample_clock_p, LINK.sample_clock_n, POWER_DOWN, NOISE_INJECTION_EN,
            OUTPUT_ENABLE_N, FORMAT_LEVEL, OUTPUT_SCRAMBLE_SEL};
         s2_reg <= s1_reg;
         clk_prev_reg <= s2_reg[7] & ~s2_reg[6];
      end
   end
   wire logic enc_high = s2_reg[7] & ~s2_reg[6]; // true side above complement
   wire logic pd = s2_reg[5];
   wire logic oe_n = s2_reg[3];
   wire logic [1:0] fmt = s2_reg[2:1];
   wire logic scr = s2_reg[0];
   wire logic rise = enc_high & ~clk_prev_reg;
   wire logic fall = ~enc_high & clk_prev_reg;
   // ----------------------------------------------------------------
   // coding and scrambling of the sampled word
   // ----------------------------------------------------------------
   wire logic twos = (fmt == `ADCP_FMT_TWO_THIRD) || (fmt == `ADCP_FMT_SUPPLY);
   wire adcp_pkg::adcp_word_t coded = twos ? {~SAMPLE_IN[15], SAMPLE_IN[14:0]} : SAMPLE_IN;
   wire adcp_pkg::adcp_word_t scrambled = scr ? {coded[15:1] ^ {15{coded[0]}}, coded[0]} : coded;
   // ----------------------------------------------------------------
   // sample pipeline, word plus flag, advanced each rising edge outside power down
   // ----------------------------------------------------------------
   logic [16:0] pipe_reg [LATENCY];
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < LATENCY; i++) pipe_reg[i] <= 17'h00000;
      end else if (rise && !pd) begin
         pipe_reg[0] <= {SAMPLE_OVER, scrambled};
         for (int i = 1; i < LATENCY; i++) pipe_reg[i] <= pipe_reg[i-1];
      end
   end
   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   logic [15:0] res_reg;
   logic flag_reg, dvn_reg, dvp_reg, oen_reg, stab_reg, noise_injection_en_reg, gain_reg;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         res_reg <= 16'h0000;
         flag_reg <= 1'b0;
         dvn_reg <= 1'b1;
         dvp_reg <= 1'b0;
         oen_reg <= 1'b1;
         stab_reg <= 1'b0;
         noise_injection_en_reg <= 1'b0;
         gain_reg <= 1'b0;
      end else begin
         if (rise && !pd) begin
            res_reg <= pipe_reg[LATENCY-1][15:0];
            flag_reg <= pipe_reg[LATENCY-1][16];
            dvn_reg <= 1'b1; // falls mid period
            dvp_reg <= 1'b0;
         end else if (fall && !pd) begin
            dvn_reg <= 1'b0;
            dvp_reg <= 1'b1;
         end
         oen_reg <= pd | oe_n;
         stab_reg <= ~pd & ((fmt == `ADCP_FMT_THIRD) || (fmt == `ADCP_FMT_TWO_THIRD));
         noise_injection_en_reg <= ~pd & s2_reg[4];
         gain_reg <= GAIN_SELECT; // static strap
      end
   end
   assign LINK.result_bus = res_reg;
   assign LINK.range_flag = flag_reg;
   assign LINK.data_valid_n = dvn_reg;
   assign LINK.data_valid_p = dvp_reg;
   assign LINK.result_bus_oe_n = oen_reg;
   assign LINK.flag_oe_n = oen_reg;
   assign STABILIZER_ON = stab_reg;
   assign DITHER_ON = noise_injection_en_reg;
   assign HIGH_GAIN = gain_reg;
endmodule
`default_nettype wire

// *** verilog/adcp_capt.sv ***
// capture end: makes the sample clock, latches words, descrambles, interrupts
// assumes software on the plain register port of this module
`timescale 1ns/100ps
`default_nettype none
`include "adcp_map.svh"
module adcp_capt #(
   parameter int CLK_DIV = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   adcp_if.capt LINK,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ
);
   // ----------------------------------------------------------------
   // sample clock divider (half period CLK_DIV cycles)
   // ----------------------------------------------------------------
   logic [7:0] div_reg;
   logic enc_reg;
   logic run_reg, descr_reg; // control bits
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= 8'h00;
         enc_reg <= 1'b0;
      end else if (div_reg == 8'(CLK_DIV - 1)) begin
         div_reg <= 8'h00;
         enc_reg <= ~enc_reg & run_reg;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   assign LINK.sample_clock_p = enc_reg;
   assign LINK.sample_clock_n = ~enc_reg;
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [18:0] s1_reg, s2_reg;
   logic dvn_prev_reg;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_reg <= 19'h7ffff;
         s2_reg <= 19'h7ffff;
         dvn_prev_reg <= 1'b1;
      end else begin
         s1_reg <= {LINK.flag_oe_n, LINK.data_valid_n, LINK.range_flag, LINK.result_bus};
         s2_reg <= s1_reg;
         dvn_prev_reg <= s2_reg[17];
      end
   end
   wire logic capture = dvn_prev_reg & ~s2_reg[17] & ~s2_reg[18];
   wire logic [15:0] raw = s2_reg[15:0];
   wire logic [15:0] plain = descr_reg ? {raw[15:1] ^ {15{raw[0]}}, raw[0]} : raw;
   // ----------------------------------------------------------------
   // capture, status and register port
   // ----------------------------------------------------------------
   logic [15:0] word_reg;
   logic [2:0] stat_reg, en_reg;
   logic fresh_reg, irq_reg;
   logic [31:0] rd_reg;
   wire logic [2:0] ev = {capture & fresh_reg, capture & s2_reg[16], capture};
   wire logic clr_wr = WR && ADDR == `ADCP_REG_CLEAR;
   wire logic [2:0] clr = clr_wr ? WDATA[2:0] : 3'h0;
   wire logic rd_data = RD && ADDR == `ADCP_REG_DATA;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         word_reg <= 16'h0000;
         stat_reg <= 3'h0;
         en_reg <= 3'h0;
         fresh_reg <= 1'b0;
         run_reg <= 1'b0;
         descr_reg <= 1'b0;
         rd_reg <= 32'h00000000;
         irq_reg <= 1'b0;
      end else begin
         if (capture) word_reg <= plain;
         stat_reg <= (stat_reg & ~clr) | ev; // set beats clear
         fresh_reg <= capture | (fresh_reg & ~rd_data);
         if (WR && ADDR == `ADCP_REG_ENABLE) en_reg <= WDATA[2:0];
         if (WR && ADDR == `ADCP_REG_CTRL) begin
            run_reg <= WDATA[0];
            descr_reg <= WDATA[1];
         end
         if (RD) begin
            case (ADDR)
               `ADCP_REG_DATA: rd_reg <= {16'h0000, word_reg};
               `ADCP_REG_STATUS: rd_reg <= {29'h0, stat_reg};
               `ADCP_REG_ENABLE: rd_reg <= {29'h0, en_reg};
               `ADCP_REG_CTRL: rd_reg <= {30'h0, descr_reg, run_reg};
               default: rd_reg <= 32'h00000000;
            endcase
         end else begin
            rd_reg <= 32'h00000000;
         end
         irq_reg <= |(((stat_reg & ~clr) | ev) & en_reg);
      end
   end
   assign RDATA = rd_reg;
   assign IRQ = irq_reg;
endmodule
`default_nettype wire

// *** sim/adcp_props.sv ***
// checker for the port between converter end and capture end
// assumes the interface signals and the capture clock domain
`timescale 1ns/100ps
`default_nettype none
module adcp_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic sample_clock_p,
   input wire logic sample_clock_n,
   input wire adcp_pkg::adcp_word_t result_bus,
   input wire logic result_bus_oe_n,
   input wire logic data_valid_n,
   input wire logic data_valid_p,
   input wire logic range_flag,
   input wire logic flag_oe_n
);
   // ----------------------------------------------------------------
   // assertions, all in the capture clock domain
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_valid_inverse: assert property (data_valid_p == !data_valid_n)
      else $error("valid outputs not complementary");
   a_clock_pair: assert property (sample_clock_n == !sample_clock_p)
      else $error("sample clock pair not complementary");
   a_word_steady: assert property ($fell(data_valid_n) |-> $stable(result_bus))
      else $error("word moved at capture edge");
   a_flag_steady: assert property ($fell(data_valid_n) |-> $stable(range_flag))
      else $error("range flag moved at capture edge");
   a_valid_after_rise: assert property ($rose(sample_clock_p) && !flag_oe_n |-> ##[2:5] (data_valid_n || flag_oe_n))
      else $error("no valid rise after sample clock rise");
   a_valid_after_fall: assert property ($fell(sample_clock_p) && !flag_oe_n |-> ##[2:5] (!data_valid_n || flag_oe_n))
      else $error("no valid fall after sample clock fall");
   a_valid_width: assert property ($rose(data_valid_n) |=> data_valid_n [*6])
      else $error("valid toggled faster than the sample rate");
   a_float_together: assert property (result_bus_oe_n == flag_oe_n)
      else $error("output enables disagree");
   // main scenarios reached
   c_capture: cover property ($fell(data_valid_n) && !flag_oe_n);
   c_float: cover property ($rose(result_bus_oe_n));
   c_range: cover property (range_flag && !flag_oe_n);
endmodule
`default_nettype wire

// *** sim/tb_adc_output_port_control.sv ***
// self-checking bench: both ends joined by the interface
// assumes the register offsets and codes of adcp_map.svh
`timescale 1ns/100ps
`default_nettype none
`include "adcp_map.svh"
module tb_adc_output_port_control;
   logic clk, rst_n, pd, noise_injection_en, oe_n, scr, gsel, over, wr, rd, stab, noise_injection_en_on, hgain, irq, x;
   logic [1:0] fmt;
   logic [15:0] smp;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, d;
   int num_errors, n_checks;
   adcp_if link ();
   adcp_conv adcp_conv_i (.CLK(clk), .RST_N(rst_n), .LINK(link), .SAMPLE_IN(smp), .SAMPLE_OVER(over),
      .POWER_DOWN(pd), .NOISE_INJECTION_EN(noise_injection_en), .OUTPUT_ENABLE_N(oe_n), .FORMAT_LEVEL(fmt),
      .OUTPUT_SCRAMBLE_SEL(scr), .GAIN_SELECT(gsel), .STABILIZER_ON(stab), .DITHER_ON(noise_injection_en_on), .HIGH_GAIN(hgain));
   adcp_capt adcp_capt_i (.CLK(clk), .RST_N(rst_n), .LINK(link), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IRQ(irq));
   adcp_props chk_i (.CLK(clk), .RST_N(rst_n), .sample_clock_p(link.sample_clock_p),
      .sample_clock_n(link.sample_clock_n), .result_bus(link.result_bus), .result_bus_oe_n(link.result_bus_oe_n),
      .data_valid_n(link.data_valid_n), .data_valid_p(link.data_valid_p), .range_flag(link.range_flag),
      .flag_oe_n(link.flag_oe_n));
   // ----------------------------------------------------------------
   // clock, helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // one idle edge so a following write never re-raises the strobe in this step
      @(posedge clk);
   endtask
   // read data stand only in the cycle after the strobe
   task rd_reg(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   task settle;
      repeat (200) @(posedge clk);
   endtask
   task results;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // word reaches the data register; interrupt raised, masked, cleared
   task t_word;
      wr_reg(`ADCP_REG_CTRL, 32'h1);
      wr_reg(`ADCP_REG_ENABLE, 32'h1);
      settle();
      rd_reg(`ADCP_REG_DATA);
      chk("data", 32'h1235, d);
      chk("irq", 32'h1, {31'h0, irq});
      rd_reg(`ADCP_REG_STATUS);
      chk("status set", 32'h5, {29'h0, d[2:0]});
      wr_reg(`ADCP_REG_ENABLE, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr_reg(`ADCP_REG_CTRL, 32'h0);
      repeat (40) @(posedge clk);
      wr_reg(`ADCP_REG_CLEAR, 32'h7);
      wr_reg(`ADCP_REG_ENABLE, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd_reg(`ADCP_REG_STATUS);
      chk("status", 32'h0, {29'h0, d[2:0]});
      rd_reg(4'hf);
      chk("unmapped", 32'h0, d);
   endtask
   // every format level: coding and stabilizer
   task t_format;
      wr_reg(`ADCP_REG_CTRL, 32'h1);
      for (int f = 0; f < 4; f++) begin
         fmt <= f[1:0];
         settle();
         chk("stabilizer", {31'h0, f == 1 || f == 2}, {31'h0, stab});
         rd_reg(`ADCP_REG_DATA);
         chk("coded", (f >= 2) ? 32'h9235 : 32'h1235, d);
      end
      fmt <= `ADCP_FMT_GND;
   endtask
   // scrambled word raw, then undone by the capture end
   task t_scramble;
      scr <= 1'b1;
      settle();
      rd_reg(`ADCP_REG_DATA);
      chk("scrambled", 32'h1235 ^ 32'hfffe, d);
      wr_reg(`ADCP_REG_CTRL, 32'h3);
      rd_reg(`ADCP_REG_CTRL);
      chk("ctrl", 32'h3, d);
      settle();
      rd_reg(`ADCP_REG_DATA);
      chk("descrambled", 32'h1235, d);
      scr <= 1'b0;
      wr_reg(`ADCP_REG_CTRL, 32'h1);
      settle();
   endtask
   // new sample and its flag reach the pins seven sample cycles after being taken:
   // the first valid fall shows the word launched at the edge already seen
   task t_latency;
      @(posedge link.data_valid_n);
      @(posedge clk);
      smp <= 16'h00f0;
      over <= 1'b1;
      for (int i = 1; i <= 9; i++) begin
         @(negedge link.data_valid_n);
         chk("wire word", (i < 9) ? 32'h1235 : 32'h00f0, {16'h0, link.result_bus});
         chk("wire flag", {31'h0, i == 9}, {31'h0, link.range_flag});
      end
      @(posedge clk);
      settle();
      rd_reg(`ADCP_REG_STATUS);
      chk("range status", 32'h1, {31'h0, d[1]});
      smp <= 16'h1235;
      over <= 1'b0;
   endtask
   // straps: dither, gain, output enable, power down
   task t_straps;
      for (int v = 1; v >= 0; v--) begin
         noise_injection_en <= v[0];
         gsel <= v[0];
         oe_n <= v[0];
         repeat (4) @(posedge clk);
         chk("dither", v, {31'h0, noise_injection_en_on});
         chk("gain", v, {31'h0, hgain});
         chk("float", v, {31'h0, link.result_bus_oe_n});
      end
      pd <= 1'b1;
      repeat (40) @(posedge clk);
      chk("pd float", 32'h1, {31'h0, link.flag_oe_n});
      x = link.data_valid_n;
      repeat (40) @(posedge clk);
      chk("pd valid", {31'h0, x}, {31'h0, link.data_valid_n});
      pd <= 1'b0;
      @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {rst_n, pd, noise_injection_en, scr, gsel, over, wr, rd, fmt, addr, wdata} = '0;
      oe_n = 1'b0;
      smp = 16'h1235;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_word();
      t_format();
      t_scramble();
      t_latency();
      t_straps();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
